// *** timer_pkg.sv ***
package timer_pkg;

    localparam logic [2:0] ADDR_COUNTER_LOW = 3'h0;
    localparam logic [2:0] ADDR_COUNTER_HIGH = 3'h1;
    localparam logic [2:0] ADDR_COMPARE_A_LOW = 3'h2;
    localparam logic [2:0] ADDR_COMPARE_A_HIGH = 3'h3;
    localparam logic [2:0] ADDR_CONTROL_ZERO = 3'h4;
    localparam logic [2:0] ADDR_CONTROL_ONE = 3'h5;
    localparam logic [2:0] ADDR_FLAGS = 3'h6;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [9:0] COUNT_MAX = 10'h3FF;

    // Control zero fields
    localparam int C0_PAUSE = 7;
    localparam int C0_CLKSEL_HI = 6;
    localparam int C0_CLKSEL_LO = 4;
    localparam int C0_ENABLE = 3;
    localparam int C0_PERIOD_HI = 2;
    localparam int C0_PERIOD_LO = 0;

    // Control one fields
    localparam int C1_MODE_HI = 7;
    localparam int C1_MODE_LO = 6;
    localparam int C1_ACTION_HI = 5;
    localparam int C1_ACTION_LO = 4;
    localparam int C1_INIT_LEVEL = 3;
    localparam int C1_INVERT = 2;
    localparam int C1_SWAP = 1;
    localparam int C1_CLEAR_SEL = 0;

    // Flag register fields, write one to clear
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;

    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;

    localparam logic [2:0] CLK_DIV4 = 3'h0;
    localparam logic [2:0] CLK_FULL = 3'h1;
    localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
    localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
    localparam logic [2:0] CLK_PIN_RISE = 3'h6;
    localparam logic [2:0] CLK_PIN_FALL = 3'h7;
    localparam logic [5:0] PRESCALE_DIV4 = 6'h03;
    localparam logic [5:0] PRESCALE_DIV16 = 6'h0F;
    localparam logic [5:0] PRESCALE_DIV64 = 6'h3F;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
        logic flag_a;
        logic flag_p;
    } timer_out_type;

endpackage

// *** tick_source.sv ***
`timescale 1ns/10ps
`default_nettype none
// Count tick generator: prescaler and synchronised external clock pin
module tick_source
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] clk_select,
    input wire logic sub_tick,
    input wire logic ext_clk_pin,
    output logic tick
);

    typedef struct packed {
        logic [5:0] prescale;
        logic [2:0] sync;
        logic pin_level;
    } tick_state_type;

    tick_state_type state_reg;
    tick_state_type state_next;

    always_comb begin
        logic agree;
        logic changed;
        agree = 1'b0;
        changed = 1'b0;
        state_next = state_reg;
        state_next.prescale = 6'(state_reg.prescale + 6'h01);
        state_next.sync = {state_reg.sync[1:0], ext_clk_pin};
        // Stage 0 feeds only stage 1; decisions use stages 1 and 2
        agree = (state_reg.sync[1] == state_reg.sync[2]);
        changed = agree && (state_reg.sync[2] != state_reg.pin_level);
        if (changed) begin
            state_next.pin_level = state_reg.sync[2];
        end
        case (clk_select)
            CLK_DIV4: tick = (state_reg.prescale[1:0] == PRESCALE_DIV4[1:0]);
            CLK_FULL: tick = 1'b1;
            CLK_HIGH_DIV16: tick = (state_reg.prescale[3:0] == PRESCALE_DIV16[3:0]);
            CLK_HIGH_DIV64: tick = (state_reg.prescale == PRESCALE_DIV64);
            CLK_PIN_RISE: tick = changed && state_reg.sync[2];
            CLK_PIN_FALL: tick = changed && !state_reg.sync[2];
            default: tick = sub_tick;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule
`default_nettype wire

// *** compact_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module compact_timer
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire bus_req_type bus_req,
    output logic [7:0] rdata,
    input wire logic sub_tick,
    input wire logic ext_clk_pin,
    output timer_out_type timer_out
);

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b01,
        RUN_ACTIVE = 2'b10
    } run_state_type;

    typedef struct packed {
        run_state_type run;
        logic [9:0] counter;
        logic [9:0] compare_a;
        logic [7:0] control_zero;
        logic [7:0] control_one;
        logic flag_a;
        logic flag_p;
        logic pin_level;
        logic pwm_level;
        logic [7:0] rdata;
    } timer_state_type;

    timer_state_type state_reg;
    timer_state_type state_next;
    logic tick;

    function automatic logic is_write(input bus_req_type req, input logic [2:0] addr);
        is_write = req.wr && (req.addr == addr);
    endfunction

    // Period match on the top three counter bits only
    function automatic logic period_match(input logic [9:0] count, input logic [2:0] period);
        period_match = (count[9:7] == period);
    endfunction

    tick_source tick_gen (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_select(state_reg.control_zero[C0_CLKSEL_HI:C0_CLKSEL_LO]),
        .sub_tick(sub_tick),
        .ext_clk_pin(ext_clk_pin),
        .tick(tick)
    );

    always_comb begin
        logic [1:0] mode;
        logic [1:0] action;
        logic [2:0] period;
        logic enable;
        logic running;
        logic match_a;
        logic match_p;
        logic clear;
        logic set_a;
        logic set_p;
        logic [10:0] period_len;
        logic [10:0] duty_len;
        logic [10:0] next_pos;
        logic [7:0] new_c0;
        logic wave;
        mode = state_reg.control_one[C1_MODE_HI:C1_MODE_LO];
        action = state_reg.control_one[C1_ACTION_HI:C1_ACTION_LO];
        period = state_reg.control_zero[C0_PERIOD_HI:C0_PERIOD_LO];
        enable = state_reg.control_zero[C0_ENABLE];
        running = 1'b0;
        match_a = 1'b0;
        match_p = 1'b0;
        clear = 1'b0;
        set_a = 1'b0;
        set_p = 1'b0;
        period_len = 11'h000;
        duty_len = 11'h000;
        next_pos = 11'h000;
        new_c0 = state_reg.control_zero;
        wave = 1'b0;
        state_next = state_reg;

        running = (state_reg.run == RUN_ACTIVE) && !state_reg.control_zero[C0_PAUSE] && tick;
        // Matches judged on the value the tick lands on
        next_pos = {1'b0, state_reg.counter} + 11'h001;
        match_a = (next_pos[9:0] == state_reg.compare_a) && !next_pos[10];
        // Period zero: the P match is the wrap past 3FF, so the P flag still rises
        if (period == 3'h0) begin
            match_p = next_pos[10];
        end else begin
            match_p = period_match(next_pos[9:0], period) && !next_pos[10];
        end

        if (mode == MODE_PWM) begin
            // Clear-select ignored here
            period_len = (period == 3'h0) ? 11'h400 : {1'b0, period, 7'h00};
            duty_len = {1'b0, state_reg.compare_a};
            if (state_reg.control_one[C1_SWAP]) begin
                duty_len = period_len;
                period_len = {1'b0, state_reg.compare_a};
            end
            set_a = running && match_a;
            set_p = running && match_p;
            clear = state_reg.control_one[C1_SWAP] ? match_a : match_p;
            if (period_len == 11'h000) begin
                clear = match_a;
            end
        end else begin
            if (state_reg.control_one[C1_CLEAR_SEL]) begin
                // A value zero never matches; counter wraps at 3FF
                set_a = running && match_a && (state_reg.compare_a != 10'h000);
                clear = match_a && (state_reg.compare_a != 10'h000);
            end else begin
                set_a = running && match_a;
                set_p = running && match_p;
                clear = match_p;
            end
        end

        if (running) begin
            if (clear || state_reg.counter == COUNT_MAX) begin
                state_next.counter = 10'h000;
            end else begin
                state_next.counter = next_pos[9:0];
            end
        end

        // PWM waveform, edge aligned; duty at or past period holds active
        if (running) begin
            if (clear || state_reg.counter == COUNT_MAX) begin
                wave = (duty_len != 11'h000);
            end else begin
                wave = (next_pos < duty_len) || (duty_len >= period_len);
            end
            state_next.pwm_level = wave;
        end

        case (state_reg.run)
            RUN_IDLE: begin
                if (enable) begin
                    state_next.run = RUN_ACTIVE;
                end
            end
            RUN_ACTIVE: begin
                if (!enable) begin
                    state_next.run = RUN_IDLE;
                end
            end
            default: state_next.run = RUN_IDLE;
        endcase

        if (mode == MODE_COMPARE && set_a) begin
            case (action)
                ACT_LOW: state_next.pin_level = 1'b0;
                ACT_HIGH: state_next.pin_level = 1'b1;
                ACT_TOGGLE: state_next.pin_level = !state_reg.pin_level;
                default: state_next.pin_level = state_reg.pin_level;
            endcase
        end

        // Flags: a new match beats a software clear in the same cycle
        if (is_write(bus_req, ADDR_FLAGS)) begin
            if (bus_req.wdata[FLAG_A_BIT]) begin
                state_next.flag_a = 1'b0;
            end
            if (bus_req.wdata[FLAG_P_BIT]) begin
                state_next.flag_p = 1'b0;
            end
        end
        if (set_a) begin
            state_next.flag_a = 1'b1;
        end
        if (set_p) begin
            state_next.flag_p = 1'b1;
        end

        if (is_write(bus_req, ADDR_COMPARE_A_LOW)) begin
            state_next.compare_a[7:0] = bus_req.wdata;
        end
        if (is_write(bus_req, ADDR_COMPARE_A_HIGH)) begin
            state_next.compare_a[9:8] = bus_req.wdata[1:0];
        end
        if (is_write(bus_req, ADDR_CONTROL_ONE)) begin
            state_next.control_one = bus_req.wdata;
        end
        if (is_write(bus_req, ADDR_CONTROL_ZERO)) begin
            new_c0 = bus_req.wdata;
            state_next.control_zero = new_c0;
            if (new_c0[C0_ENABLE] && !enable) begin
                state_next.counter = 10'h000;
                state_next.pin_level = state_reg.control_one[C1_INIT_LEVEL];
                state_next.pwm_level = 1'b0;
                state_next.run = RUN_IDLE;
            end
        end

        state_next.rdata = RESET_BYTE;
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_COUNTER_LOW: state_next.rdata = state_reg.counter[7:0];
                ADDR_COUNTER_HIGH: state_next.rdata = {6'h00, state_reg.counter[9:8]};
                ADDR_COMPARE_A_LOW: state_next.rdata = state_reg.compare_a[7:0];
                ADDR_COMPARE_A_HIGH: state_next.rdata = {6'h00, state_reg.compare_a[9:8]};
                ADDR_CONTROL_ZERO: state_next.rdata = state_reg.control_zero;
                ADDR_CONTROL_ONE: state_next.rdata = state_reg.control_one;
                ADDR_FLAGS: state_next.rdata = {6'h00, state_reg.flag_p, state_reg.flag_a};
                default: state_next.rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.run <= RUN_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Output pin shaping per mode
    always_comb begin
        logic [1:0] mode;
        logic active_high;
        logic level;
        mode = state_reg.control_one[C1_MODE_HI:C1_MODE_LO];
        active_high = state_reg.control_one[C1_INIT_LEVEL];
        level = 1'b0;
        timer_out.pin_oe = 1'b0;
        case (mode)
            MODE_COMPARE: begin
                level = state_reg.pin_level;
                timer_out.pin_oe = 1'b1;
            end
            MODE_PWM: begin
                timer_out.pin_oe = 1'b1;
                case (state_reg.control_one[C1_ACTION_HI:C1_ACTION_LO])
                    PWM_FORCE_INACTIVE: level = !active_high;
                    PWM_FORCE_ACTIVE: level = active_high;
                    PWM_WAVE: level = state_reg.pwm_level ? active_high : !active_high;
                    default: level = !active_high;
                endcase
            end
            default: begin
                level = 1'b0;
                timer_out.pin_oe = 1'b0;
            end
        endcase
        timer_out.pin_out = timer_out.pin_oe && (level ^ state_reg.control_one[C1_INVERT]);
        timer_out.flag_a = state_reg.flag_a;
        timer_out.flag_p = state_reg.flag_p;
    end

    assign rdata = state_reg.rdata;

endmodule
`default_nettype wire

// *** compact_timer_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module compact_timer_sva
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire bus_req_type bus_req,
    input wire logic [7:0] rdata,
    input wire timer_out_type timer_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Shadow of the software-visible settings, rebuilt from bus writes
    logic [9:0] a_q;
    logic [7:0] c1_q;
    logic en_q;
    logic pwm_q;
    logic clr_q;
    logic a_zero;
    assign pwm_q = (c1_q[7:6] == MODE_PWM);
    assign clr_q = c1_q[C1_CLEAR_SEL];
    assign a_zero = (a_q == 10'h000);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            a_q <= 10'h000;
            c1_q <= 8'h00;
            en_q <= 1'b0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == ADDR_COMPARE_A_LOW) a_q[7:0] <= bus_req.wdata;
            if (bus_req.addr == ADDR_COMPARE_A_HIGH) a_q[9:8] <= bus_req.wdata[1:0];
            if (bus_req.addr == ADDR_CONTROL_ONE) c1_q <= bus_req.wdata;
            if (bus_req.addr == ADDR_CONTROL_ZERO) en_q <= bus_req.wdata[C0_ENABLE];
        end
    end
    property p_rdata_idle;
        !$past(bus_req.rd) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero outside a read");
    property p_cnt_hi;
        $past(bus_req.rd) && $past(bus_req.addr) == ADDR_COUNTER_HIGH |-> rdata[7:2] == 6'h00;
    endproperty
    a_cnt_hi: assert property (p_cnt_hi) else $error("counter high byte upper bits set");
    property p_a_lo;
        $past(bus_req.rd) && $past(bus_req.addr) == ADDR_COMPARE_A_LOW |-> rdata == a_q[7:0];
    endproperty
    a_a_lo: assert property (p_a_lo) else $error("compare A low byte readback wrong");
    property p_a_hi;
        $past(bus_req.rd) && $past(bus_req.addr) == ADDR_COMPARE_A_HIGH |-> rdata == {6'h00, a_q[9:8]};
    endproperty
    a_a_hi: assert property (p_a_hi) else $error("compare A high byte readback wrong");
    property p_oe;
        timer_out.pin_oe == (c1_q[7:6] == MODE_COMPARE || c1_q[7:6] == MODE_PWM);
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong for mode");
    property p_init;
        bus_req.wr && bus_req.addr == ADDR_CONTROL_ZERO && bus_req.wdata[C0_ENABLE] && !en_q
            && c1_q[7:6] == MODE_COMPARE && !c1_q[C1_INVERT] |=> timer_out.pin_out == c1_q[C1_INIT_LEVEL];
    endproperty
    a_init: assert property (p_init) else $error("pin not loaded on enable");
    property p_pin_cause;
        c1_q[7:6] == MODE_COMPARE && !$past(bus_req.wr) && $changed(timer_out.pin_out) |-> timer_out.flag_a;
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin moved without A match");
    property p_p_never;
        $rose(timer_out.flag_p) |-> $past(pwm_q) || !$past(clr_q);
    endproperty
    a_p_never: assert property (p_p_never) else $error("P flag set with A clearing");
    property p_a_zero;
        $rose(timer_out.flag_a) |-> $past(pwm_q) || !$past(clr_q) || !$past(a_zero);
    endproperty
    a_a_zero: assert property (p_a_zero) else $error("A flag set with A value zero");
    property p_force;
        en_q && pwm_q && !c1_q[C1_ACTION_HI]
            |-> timer_out.pin_out == (c1_q[C1_INIT_LEVEL] ^ c1_q[C1_INVERT] ^ !c1_q[C1_ACTION_LO]);
    endproperty
    a_force: assert property (p_force) else $error("forced PWM level wrong");
endmodule
bind compact_timer compact_timer_sva u_compact_timer_sva (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
    .rdata(rdata), .timer_out(timer_out));
`default_nettype wire

// *** compact_timer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module compact_timer_tb
    import timer_pkg::*;
;
    `define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
        $display("[FAIL] %s exp %h got %h", n, e, g); end end
    typedef struct packed {
        logic swap;
        logic inv;
        logic [1:0] act;
        logic [9:0] a;
        logic [2:0] p;
        logic [10:0] per;
        logic [10:0] hi;
        logic [7:0] fl;
    } pwm_case_type;
    pwm_case_type tab[7] = '{
        '{1'b0, 1'b0, 2'h2, 10'h020, 3'h1, 11'h080, 11'h020, 8'h03},
        '{1'b0, 1'b1, 2'h2, 10'h020, 3'h1, 11'h080, 11'h060, 8'h03},
        '{1'b0, 1'b0, 2'h2, 10'h0C8, 3'h1, 11'h080, 11'h080, 8'h02},
        '{1'b1, 1'b0, 2'h2, 10'h12C, 3'h1, 11'h12C, 11'h080, 8'h03},
        '{1'b0, 1'b0, 2'h0, 10'h020, 3'h1, 11'h080, 11'h000, 8'h03},
        '{1'b0, 1'b0, 2'h1, 10'h020, 3'h1, 11'h080, 11'h080, 8'h03},
        '{1'b0, 1'b0, 2'h2, 10'h020, 3'h0, 11'h400, 11'h020, 8'h03}};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    bus_req_type bus_req = '0;
    logic [7:0] rdata;
    timer_out_type timer_out;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;
    logic [7:0] d;
    logic rd_pend = 1'b0;
    logic lvl;
    int error_cnt = 0;
    int check_count = 0;
    int seed = 62;
    int cnt;
    compact_timer u_compact_timer (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rdata(rdata),
        .sub_tick(1'b0), .ext_clk_pin(1'b0), .timer_out(timer_out));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) rd_pend <= bus_req.rd;
    // Read data stands one cycle only, so it is taken mid-cycle
    always @(negedge ref_clk) begin
        if (rd_pend === 1'b1) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK("rdata", exp_v, rdata)
        end
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Mode bits change only while stopped, as software must
    task automatic run(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p);
        wr(ADDR_CONTROL_ZERO, 8'h10);
        wr(ADDR_COMPARE_A_LOW, a[7:0]);
        wr(ADDR_COMPARE_A_HIGH, {6'h00, a[9:8]});
        wr(ADDR_CONTROL_ONE, c1);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CONTROL_ZERO, {5'h03, p});
        cyc(1);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        $display("[FAIL] run time limit exp end got none");
        stop_test();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd(i[2:0], RESET_BYTE);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(ADDR_COMPARE_A_LOW, d);
            wr(ADDR_COMPARE_A_HIGH, ~d);
            wr(ADDR_COUNTER_LOW, d);
            rd(ADDR_COMPARE_A_LOW, d);
            rd(ADDR_COMPARE_A_HIGH, {6'h00, ~d[1:0]});
            rd(3'h7, 8'h00);
            rd(ADDR_COUNTER_LOW, 8'h00);
        end
        done("registers");
        for (int k = 0; k < 4; k++) begin
            lvl = ~k[1];
            run({MODE_COMPARE, k[1:0], lvl, 3'h1}, 10'h0C8, 3'h1);
            `CHK("pin initial", lvl, timer_out.pin_out)
            cyc(250);
            `CHK("pin action", (k != 1), timer_out.pin_out)
            rd(ADDR_FLAGS, 8'h01);
        end
        run({MODE_COMPARE, ACT_TOGGLE, 1'b0, 3'h0}, 10'h032, 3'h1);
        cyc(200);
        `CHK("pin after P", 1'b0, timer_out.pin_out)
        cyc(70);
        rd(ADDR_FLAGS, 8'h03);
        rd(ADDR_COUNTER_HIGH, 8'h00);
        wr(ADDR_CONTROL_ZERO, 8'h10);
        wr(ADDR_CONTROL_ZERO, 8'h98);
        rd(ADDR_COUNTER_LOW, 8'h00);
        done("compare");
        run({MODE_COMPARE, ACT_TOGGLE, 1'b0, 3'h1}, 10'h000, 3'h1);
        cyc(1100);
        rd(ADDR_FLAGS, 8'h00);
        `CHK("pin no match", 1'b0, timer_out.pin_out)
        run({MODE_TIMER, ACT_TOGGLE, 1'b0, 3'h1}, 10'h0C8, 3'h1);
        cyc(250);
        `CHK("pin_oe", 1'b0, timer_out.pin_oe)
        rd(ADDR_FLAGS, 8'h01);
        done("timer");
        foreach (tab[i]) begin
            run({MODE_PWM, tab[i].act, 1'b1, tab[i].inv, tab[i].swap, 1'b1}, tab[i].a, tab[i].p);
            cyc(5);
            cnt = 0;
            repeat (tab[i].per) begin
                cyc(1);
                cnt += (timer_out.pin_out === 1'b1);
            end
            `CHK("pwm high count", tab[i].hi, cnt[10:0])
            rd(ADDR_FLAGS, tab[i].fl);
        end
        done("pwm");
        cyc(2);
        `CHK("pending reads", 0, exp_q.size())
        stop_test();
    end
endmodule
`default_nettype wire
